// [pkg/rtm_pkg.sv]
// package for the reload timer: register offsets, control field layout,
// reset values, prescale count and the structs that carry bus and state.
// assumes an 8-bit special-function-register bus with a byte address.
package rtm_pkg;

  // ---------------------------------------------------------------
  // register offsets on the special-function-register bus
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'hC8;
  localparam logic [7:0] OFS_TIMER_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] OFS_TIMER_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] OFS_TIMER_COUNT_LOW = 8'hCC;
  localparam logic [7:0] OFS_TIMER_COUNT_HIGH = 8'hCD;

  // ---------------------------------------------------------------
  // control field positions and values after reset
  // ---------------------------------------------------------------
  localparam int BIT_HIGH_OVERFLOW_FLAG = 7;
  localparam int BIT_LOW_OVERFLOW_FLAG = 6;
  localparam int BIT_LOW_BYTE_IRQ_ENABLE = 5;
  localparam int BIT_CAPTURE_MODE_ENABLE = 4;
  localparam int BIT_SPLIT_MODE_SELECT = 3;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_UNUSED = 1;
  localparam int BIT_ALTERNATE_CLOCK_SELECT = 0;
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam int SYSTEM_CLOCK_DIVIDE = 12;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_mode_enable;
    logic split_mode_select;
    logic run_control;
    logic unused;
    logic alternate_clock_select;
  } rtm_ctrl_t;

  // one bus write request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtm_sfr_req_t;

  // whole state of the timer core
  typedef struct packed {
    rtm_ctrl_t ctrl;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic [7:0] rdata;
  } rtm_state_t;

  // state of the divide-by-n tick generator
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } rtm_div_state_t;

  // state of the synchroniser with falling-edge detect
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic fall;
  } rtm_sync_state_t;

endpackage

// [verilog/rtm_prescale.sv]
// divide-by-n tick generator: one-cycle pulse every DIV system clocks.
// assumes DIV fits the 8-bit counter held in the package state type.
module rtm_prescale #(
  parameter int DIV = rtm_pkg::SYSTEM_CLOCK_DIVIDE
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  localparam logic [7:0] LAST = 8'(DIV - 1);

  rtm_pkg::rtm_div_state_t st_reg;
  rtm_pkg::rtm_div_state_t st_next;

  // free-running count, pulse on the last step
  always_comb begin
    st_next = st_reg;
    st_next.tick = (st_reg.cnt == LAST);
    st_next.cnt = (st_reg.cnt == LAST) ? 8'h00 : st_reg.cnt + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  property p_tick_period;
    @(posedge clk) disable iff (!rst_n) tick |=> !tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("prescale tick lasted more than one cycle");

endmodule

// [verilog/rtm_sync_fall.sv]
// two-flop synchroniser for the divided external oscillator, then a
// registered falling-edge pulse. assumes the input is slower than clk/2.
module rtm_sync_fall (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic fall
);

  rtm_pkg::rtm_sync_state_t st_reg;
  rtm_pkg::rtm_sync_state_t st_next;

  // s1 feeds only s2; edge detect looks at s2 and s3
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.fall = st_reg.s3 & ~st_reg.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fall = st_reg.fall;

endmodule

// [verilog/rtm_timer.sv]
// reload timer core: 16-bit auto-reload, split 8-bit pair, capture mode,
// overflow flags and the timer interrupt request, behind the sfr bus.
// assumes the fast-clock selects and interrupt enable come from registers
// elsewhere, and the divided external oscillator is asynchronous.

// How it works
// - high flag sets when high byte rolls FF to 00: 16-bit wrap, or high byte wrap in split.
// - timer irq follows a set high flag while the timer irq is enabled.
// - hardware never clears the high flag; software writes zero to clear.
// - low flag sets on every low byte roll FF to 00, any mode.
// - low flag stays set until software writes it to zero.
// - low flag drives irq only with low irq enable and timer irq enable.
// - control bit 4 turns capture mode on or off.
// - control bit 3 picks one 16-bit timer or two 8-bit timers.
// - run bit gates whole timer in 16-bit mode, only high byte in split.
// - control bit 1 reads zero and ignores writes.
// - bit 0 picks alternate clock: system_clock/12 or external oscillator/8.
// - in split mode the alternate clock serves both bytes.
// - two 8-bit read-write reload registers, low and high byte.
// - count registers form one 16-bit count, or two separate 8-bit counts.
// - on 16-bit wrap the reload value replaces zero and high flag sets.
// - in split mode each byte reloads from its own reload register.
// - each byte fast select: 1 system clock, 0 alternate clock; high select used only in split mode.
// - capture copies count to reload on external/8 fall, sets high flag.
module rtm_timer (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic HIGH_BYTE_FAST_CLOCK_SELECT,
  input wire logic LOW_BYTE_FAST_CLOCK_SELECT,
  input wire logic TIMER_IRQ_ENABLE,
  input wire logic EXT_OSC_DIV8,
  output logic TIMER_IRQ
);

  // ---------------------------------------------------------------
  // clock enables
  // ---------------------------------------------------------------
  rtm_pkg::rtm_state_t st_reg;
  rtm_pkg::rtm_state_t st_next;
  rtm_pkg::rtm_sfr_req_t req;
  logic div12_tick;
  logic ext_fall;
  logic alt_tick;
  logic low_tick;
  logic high_tick;

  assign req = '{wr: SFR_WR, addr: SFR_ADDR, wdata: SFR_WDATA};

  // divided sources become single-cycle enables on CLK
  rtm_prescale #(
    .DIV(rtm_pkg::SYSTEM_CLOCK_DIVIDE)
  ) u_div12 (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(div12_tick)
  );

  // the external source is slow and asynchronous, so it is synchronised
  rtm_sync_fall u_ext (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in(EXT_OSC_DIV8),
    .fall(ext_fall)
  );

  // clock choice per byte; high byte follows the low select unless split
  always_comb begin
    alt_tick = st_reg.ctrl.alternate_clock_select ? ext_fall : div12_tick;
    low_tick = LOW_BYTE_FAST_CLOCK_SELECT ? 1'b1 : alt_tick;
    if (st_reg.ctrl.split_mode_select) begin
      high_tick = HIGH_BYTE_FAST_CLOCK_SELECT ? 1'b1 : alt_tick;
    end else begin
      high_tick = low_tick;
    end
  end

  // ---------------------------------------------------------------
  // counting, flags and register writes
  // ---------------------------------------------------------------
  logic low_roll;
  logic high_roll;
  logic capture;
  logic wr_ctrl;
  logic wr_rld_lo;
  logic wr_rld_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;

  assign wr_ctrl = req.wr && (req.addr == rtm_pkg::OFS_TIMER_CONTROL);
  assign wr_rld_lo = req.wr && (req.addr == rtm_pkg::OFS_TIMER_RELOAD_LOW);
  assign wr_rld_hi = req.wr && (req.addr == rtm_pkg::OFS_TIMER_RELOAD_HIGH);
  assign wr_cnt_lo = req.wr && (req.addr == rtm_pkg::OFS_TIMER_COUNT_LOW);
  assign wr_cnt_hi = req.wr && (req.addr == rtm_pkg::OFS_TIMER_COUNT_HIGH);
  assign capture = st_reg.ctrl.capture_mode_enable && ext_fall;

  // one pass builds the next state; control writes first, hardware flag sets after,
  // so a hardware flag set in the same cycle always survives
  always_comb begin
    st_next = st_reg;
    low_roll = 1'b0;
    high_roll = 1'b0;

    // software writes
    if (wr_ctrl) begin
      st_next.ctrl = rtm_pkg::rtm_ctrl_t'(req.wdata);
      st_next.ctrl.unused = 1'b0;
    end
    if (wr_rld_lo) begin
      st_next.reload_low = req.wdata;
    end
    if (wr_rld_hi) begin
      st_next.reload_high = req.wdata;
    end

    if (!st_reg.ctrl.split_mode_select) begin
      // one 16-bit counter, gated whole by run
      if (st_reg.ctrl.run_control && low_tick) begin
        low_roll = (st_reg.count_low == rtm_pkg::BYTE_MAX);
        high_roll = low_roll && (st_reg.count_high == rtm_pkg::BYTE_MAX);
        if (high_roll) begin
          st_next.count_low = st_reg.reload_low;
          st_next.count_high = st_reg.reload_high;
        end else begin
          {st_next.count_high, st_next.count_low} =
            {st_reg.count_high, st_reg.count_low} + 16'h0001;
        end
      end
    end else begin
      // low byte always runs in split mode
      if (low_tick) begin
        low_roll = (st_reg.count_low == rtm_pkg::BYTE_MAX);
        st_next.count_low = low_roll ? st_reg.reload_low : st_reg.count_low + 8'h01;
      end
      // high byte gated by run
      if (st_reg.ctrl.run_control && high_tick) begin
        high_roll = (st_reg.count_high == rtm_pkg::BYTE_MAX);
        st_next.count_high = high_roll ? st_reg.reload_high : st_reg.count_high + 8'h01;
      end
    end

    // a count write overrides the counter in its own cycle
    if (wr_cnt_lo) begin
      st_next.count_low = req.wdata;
    end
    if (wr_cnt_hi) begin
      st_next.count_high = req.wdata;
    end

    // capture beats a same-cycle reload write: the snapshot is the point
    if (capture) begin
      st_next.reload_low = st_reg.count_low;
      st_next.reload_high = st_reg.count_high;
    end

    // flags only ever set here, never cleared by hardware
    if (high_roll || capture) begin
      st_next.ctrl.high_overflow_flag = 1'b1;
    end
    if (low_roll) begin
      st_next.ctrl.low_overflow_flag = 1'b1;
    end

    // registered read data, one cycle behind the address
    case (req.addr)
      rtm_pkg::OFS_TIMER_CONTROL: st_next.rdata = st_reg.ctrl;
      rtm_pkg::OFS_TIMER_RELOAD_LOW: st_next.rdata = st_reg.reload_low;
      rtm_pkg::OFS_TIMER_RELOAD_HIGH: st_next.rdata = st_reg.reload_high;
      rtm_pkg::OFS_TIMER_COUNT_LOW: st_next.rdata = st_reg.count_low;
      rtm_pkg::OFS_TIMER_COUNT_HIGH: st_next.rdata = st_reg.count_high;
      default: st_next.rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '{ctrl: rtm_pkg::rtm_ctrl_t'(rtm_pkg::RST_TIMER_CONTROL),
                  reload_low: rtm_pkg::RST_BYTE, reload_high: rtm_pkg::RST_BYTE,
                  count_low: rtm_pkg::RST_BYTE, count_high: rtm_pkg::RST_BYTE,
                  rdata: rtm_pkg::RST_BYTE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign SFR_RDATA = st_reg.rdata;

  // level request from the sticky flags; low flag needs its own enable
  assign TIMER_IRQ = TIMER_IRQ_ENABLE && (st_reg.ctrl.high_overflow_flag ||
                     (st_reg.ctrl.low_overflow_flag && st_reg.ctrl.low_byte_irq_enable));

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_wrap16;
    !st_reg.ctrl.split_mode_select && st_reg.ctrl.run_control && low_tick &&
    st_reg.count_low == 8'hFF && st_reg.count_high == 8'hFF;
  endsequence

  sequence s_clear_write(int b);
    wr_ctrl && !req.wdata[b];
  endsequence

  property p_hi_flag_on_wrap;
    s_wrap16 |=> st_reg.ctrl.high_overflow_flag;
  endproperty
  a_hi_flag_on_wrap: assert property (p_hi_flag_on_wrap) else $error("high flag missed on wrap");

  property p_reload_on_wrap;
    (s_wrap16 and (!wr_cnt_lo && !wr_cnt_hi)) |=>
      st_reg.count_low == $past(st_reg.reload_low) && st_reg.count_high == $past(st_reg.reload_high);
  endproperty
  a_reload_on_wrap: assert property (p_reload_on_wrap) else $error("reload not loaded on wrap");

  property p_hi_flag_sticky;
    st_reg.ctrl.high_overflow_flag && !(wr_ctrl && !req.wdata[rtm_pkg::BIT_HIGH_OVERFLOW_FLAG]) |=>
      st_reg.ctrl.high_overflow_flag;
  endproperty
  a_hi_flag_sticky: assert property (p_hi_flag_sticky) else $error("high flag cleared by hardware");

  property p_lo_flag_sticky;
    st_reg.ctrl.low_overflow_flag && !(wr_ctrl && !req.wdata[6]) |=> st_reg.ctrl.low_overflow_flag;
  endproperty
  a_lo_flag_sticky: assert property (p_lo_flag_sticky) else $error("low flag cleared by hardware");

  property p_lo_flag_on_roll;
    st_reg.ctrl.split_mode_select && low_tick && st_reg.count_low == 8'hFF |=>
      st_reg.ctrl.low_overflow_flag;
  endproperty
  a_lo_flag_on_roll: assert property (p_lo_flag_on_roll) else $error("low flag missed on roll");

  property p_irq_low_gated;
    TIMER_IRQ |-> TIMER_IRQ_ENABLE &&
      (st_reg.ctrl.high_overflow_flag || st_reg.ctrl.low_byte_irq_enable);
  endproperty
  a_irq_low_gated: assert property (p_irq_low_gated) else $error("irq without its enables");

  property p_irq_on_hi;
    TIMER_IRQ_ENABLE && st_reg.ctrl.high_overflow_flag |-> TIMER_IRQ;
  endproperty
  a_irq_on_hi: assert property (p_irq_on_hi) else $error("irq missing for high flag");

  property p_unused_reads_zero;
    req.addr == rtm_pkg::OFS_TIMER_CONTROL |=> !SFR_RDATA[1];
  endproperty
  a_unused_reads_zero: assert property (p_unused_reads_zero) else $error("unused control bit read one");

  property p_capture_copies;
    capture |=> st_reg.reload_low == $past(st_reg.count_low) &&
      st_reg.reload_high == $past(st_reg.count_high) && st_reg.ctrl.high_overflow_flag;
  endproperty
  a_capture_copies: assert property (p_capture_copies) else $error("capture did not copy count");

  property p_run_gates_16;
    !st_reg.ctrl.split_mode_select && !st_reg.ctrl.run_control && !wr_cnt_lo && !wr_cnt_hi |=>
      $stable(st_reg.count_low) && $stable(st_reg.count_high);
  endproperty
  a_run_gates_16: assert property (p_run_gates_16) else $error("16-bit count moved while stopped");

  property p_split_low_runs;
    st_reg.ctrl.split_mode_select && low_tick && !wr_cnt_lo && st_reg.count_low != 8'hFF |=>
      st_reg.count_low == $past(st_reg.count_low) + 8'h01;
  endproperty
  a_split_low_runs: assert property (p_split_low_runs) else $error("split low byte did not count");

  // software clears: a zero written to a flag sticks unless hardware sets it
  property p_hi_flag_clear;
    s_clear_write(rtm_pkg::BIT_HIGH_OVERFLOW_FLAG) ##0 (!high_roll && !capture) |=>
      !st_reg.ctrl.high_overflow_flag;
  endproperty
  a_hi_flag_clear: assert property (p_hi_flag_clear) else $error("high flag not cleared by write");

  property p_lo_flag_clear;
    s_clear_write(rtm_pkg::BIT_LOW_OVERFLOW_FLAG) ##0 !low_roll |=>
      !st_reg.ctrl.low_overflow_flag;
  endproperty
  a_lo_flag_clear: assert property (p_lo_flag_clear) else $error("low flag not cleared by write");

  property p_set_beats_write;
    wr_ctrl && low_roll |=> st_reg.ctrl.low_overflow_flag;
  endproperty
  a_set_beats_write: assert property (p_set_beats_write) else $error("write beat a same-cycle flag set");

  property p_lo_flag_16;
    !st_reg.ctrl.split_mode_select && st_reg.ctrl.run_control && low_tick && st_reg.count_low == 8'hFF |=>
      st_reg.ctrl.low_overflow_flag;
  endproperty
  a_lo_flag_16: assert property (p_lo_flag_16) else $error("low flag missed in 16-bit mode");

  property p_split_hi_reload;
    st_reg.ctrl.split_mode_select && st_reg.ctrl.run_control && high_tick && st_reg.count_high == 8'hFF &&
      !wr_cnt_hi |=> st_reg.count_high == $past(st_reg.reload_high) && st_reg.ctrl.high_overflow_flag;
  endproperty
  a_split_hi_reload: assert property (p_split_hi_reload) else $error("split high reload missed");

  property p_split_lo_reload;
    st_reg.ctrl.split_mode_select && low_tick && st_reg.count_low == 8'hFF && !wr_cnt_lo |=>
      st_reg.count_low == $past(st_reg.reload_low);
  endproperty
  a_split_lo_reload: assert property (p_split_lo_reload) else $error("split low reload missed");

  property p_split_hi_stops;
    st_reg.ctrl.split_mode_select && !st_reg.ctrl.run_control && !wr_cnt_hi |=>
      $stable(st_reg.count_high);
  endproperty
  a_split_hi_stops: assert property (p_split_hi_stops) else $error("split high byte moved while stopped");

  property p_ctrl_write;
    wr_ctrl |=> st_reg.ctrl[5:0] == ($past(req.wdata[5:0]) & 6'h3D);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_count_16;
    !st_reg.ctrl.split_mode_select && st_reg.ctrl.run_control && LOW_BYTE_FAST_CLOCK_SELECT &&
      !wr_cnt_lo && !wr_cnt_hi && !(st_reg.count_high == 8'hFF && st_reg.count_low == 8'hFF) |=>
      {st_reg.count_high, st_reg.count_low} == $past({st_reg.count_high, st_reg.count_low}) + 16'h0001;
  endproperty
  a_count_16: assert property (p_count_16) else $error("16-bit count did not step");

  property p_alt_ext_idle;
    !st_reg.ctrl.split_mode_select && st_reg.ctrl.run_control && !LOW_BYTE_FAST_CLOCK_SELECT &&
      st_reg.ctrl.alternate_clock_select && !ext_fall && !wr_cnt_lo && !wr_cnt_hi |=>
      $stable(st_reg.count_low) && $stable(st_reg.count_high);
  endproperty
  a_alt_ext_idle: assert property (p_alt_ext_idle) else $error("count moved without an external fall");

  property p_capture_off;
    !st_reg.ctrl.capture_mode_enable && !wr_rld_lo |=> $stable(st_reg.reload_low);
  endproperty
  a_capture_off: assert property (p_capture_off) else $error("reload changed with capture off");

  property p_split_hi_alt;
    st_reg.ctrl.split_mode_select && st_reg.ctrl.run_control && !HIGH_BYTE_FAST_CLOCK_SELECT &&
      st_reg.ctrl.alternate_clock_select && !ext_fall && !wr_cnt_hi |=> $stable(st_reg.count_high);
  endproperty
  a_split_hi_alt: assert property (p_split_hi_alt) else $error("split high byte off its clock");

endmodule

// [verif/rtm_timer_tb.sv]
// self-checking testbench for the reload timer core: bus reads and writes,
// overflow flags, reload, split mode, clock sources, capture, irq request.
// assumes rtm_pkg and the rtm_timer design files are compiled before it.
module rtm_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // signals and counters
  // ---------------------------------------------------------------
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SFR_WR = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [7:0] SFR_WDATA = 8'h00;
  logic [7:0] SFR_RDATA;
  logic HIGH_BYTE_FAST_CLOCK_SELECT = 1'b0;
  logic LOW_BYTE_FAST_CLOCK_SELECT = 1'b0;
  logic TIMER_IRQ_ENABLE = 1'b0;
  logic EXT_OSC_DIV8 = 1'b1;
  logic TIMER_IRQ;
  logic ext_run = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int ext_cnt = 0;
  logic [7:0] d;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [15:0] cap;

  rtm_timer dut (
    .CLK(CLK),
    .RST_N(RST_N),
    .SFR_WR(SFR_WR),
    .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA),
    .HIGH_BYTE_FAST_CLOCK_SELECT(HIGH_BYTE_FAST_CLOCK_SELECT),
    .LOW_BYTE_FAST_CLOCK_SELECT(LOW_BYTE_FAST_CLOCK_SELECT),
    .TIMER_IRQ_ENABLE(TIMER_IRQ_ENABLE),
    .EXT_OSC_DIV8(EXT_OSC_DIV8),
    .TIMER_IRQ(TIMER_IRQ)
  );

  // 100 MHz system clock
  always #5 CLK = ~CLK;

  // external source already divided: 40-cycle period, phase set by the bench
  always @(negedge CLK) begin
    if (ext_run) begin
      ext_cnt = (ext_cnt == 19) ? 0 : ext_cnt + 1;
      if (ext_cnt == 0) begin
        EXT_OSC_DIV8 <= ~EXT_OSC_DIV8;
      end
    end
  end

  // hang guard: whole run needs well under 5000 cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks; all enter and leave just after a falling edge
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe is dropped for a full cycle so back-to-back writes stay clean
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    SFR_WR = 1'b1;
    SFR_ADDR = a;
    SFR_WDATA = v;
    @(negedge CLK);
    SFR_WR = 1'b0;
    @(negedge CLK);
  endtask

  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    SFR_ADDR = a;
    @(negedge CLK);
    v = SFR_RDATA;
  endtask

  // polls the control register until all bits of mask are set, bounded
  task automatic wait_flag(input logic [7:0] mask);
    for (int i = 0; i < 300; i++) begin
      rd(rtm_pkg::OFS_TIMER_CONTROL, d);
      if ((d & mask) == mask) break;
    end
  endtask

  task automatic set_count(input logic [7:0] h, input logic [7:0] l);
    wr(rtm_pkg::OFS_TIMER_COUNT_HIGH, h);
    wr(rtm_pkg::OFS_TIMER_COUNT_LOW, l);
  endtask

  task automatic in_range(input logic [7:0] v, input logic [7:0] a, input logic [7:0] b);
    chk({7'h00, (v >= a && v <= b)}, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] offs [5] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk(d, rtm_pkg::RST_BYTE);
    end
    rd(8'hC9, d);
    chk(d, 8'h00);
    chk({7'h00, TIMER_IRQ}, 8'h00);
    $display("test reset done");
  endtask

  // register access, unused bit, flag write and irq combinations
  task automatic t_regs();
    logic [7:0] cv [6] = '{8'h80, 8'h80, 8'h40, 8'h60, 8'h20, 8'h60};
    logic [5:0] en = 6'b101110;
    logic [5:0] irq = 6'b100100;
    wr(rtm_pkg::OFS_TIMER_RELOAD_LOW, 8'hA5);
    wr(rtm_pkg::OFS_TIMER_RELOAD_HIGH, 8'h5A);
    set_count(8'hC3, 8'h3C);
    rd(rtm_pkg::OFS_TIMER_RELOAD_LOW, d);
    chk(d, 8'hA5);
    rd(rtm_pkg::OFS_TIMER_RELOAD_HIGH, d);
    chk(d, 8'h5A);
    rd(rtm_pkg::OFS_TIMER_COUNT_LOW, d);
    chk(d, 8'h3C);
    rd(rtm_pkg::OFS_TIMER_COUNT_HIGH, d);
    chk(d, 8'hC3);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h02);
    rd(rtm_pkg::OFS_TIMER_CONTROL, d);
    chk(d, 8'h00);
    foreach (cv[i]) begin
      TIMER_IRQ_ENABLE = en[5 - i];
      wr(rtm_pkg::OFS_TIMER_CONTROL, cv[i]);
      rd(rtm_pkg::OFS_TIMER_CONTROL, d);
      chk(d, cv[i]);
      chk({7'h00, TIMER_IRQ}, {7'h00, irq[5 - i]});
    end
    repeat (30) @(negedge CLK);
    rd(rtm_pkg::OFS_TIMER_CONTROL, d);
    chk(d, 8'h60);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h00);
    rd(rtm_pkg::OFS_TIMER_CONTROL, d);
    chk(d, 8'h00);
    $display("test registers done");
  endtask

  // 16-bit wrap at full speed, reload, flags, irq, then run gating
  task automatic t_wrap16();
    wr(rtm_pkg::OFS_TIMER_RELOAD_LOW, 8'h00);
    wr(rtm_pkg::OFS_TIMER_RELOAD_HIGH, 8'h12);
    set_count(8'hFF, 8'hF0);
    LOW_BYTE_FAST_CLOCK_SELECT = 1'b1;
    TIMER_IRQ_ENABLE = 1'b1;
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h04);
    wait_flag(8'hC0);
    chk(d, 8'hC4);
    chk({7'h00, TIMER_IRQ}, 8'h01);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'hC0);
    rd(rtm_pkg::OFS_TIMER_COUNT_HIGH, d);
    chk(d, 8'h12);
    rd(rtm_pkg::OFS_TIMER_COUNT_LOW, lo);
    in_range(lo, 8'h01, 8'h0F);
    repeat (20) @(negedge CLK);
    rd(rtm_pkg::OFS_TIMER_COUNT_LOW, d);
    chk(d, lo);
    rd(rtm_pkg::OFS_TIMER_CONTROL, d);
    chk(d, 8'hC0);
    $display("test wrap16 done");
  endtask

  // split mode: low runs without run bit, each byte its own reload
  task automatic t_split();
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h00);
    wr(rtm_pkg::OFS_TIMER_RELOAD_LOW, 8'hE0);
    wr(rtm_pkg::OFS_TIMER_RELOAD_HIGH, 8'h80);
    set_count(8'h77, 8'hF8);
    HIGH_BYTE_FAST_CLOCK_SELECT = 1'b1;
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h08);
    wait_flag(8'h40);
    chk(d, 8'h48);
    chk({7'h00, TIMER_IRQ}, 8'h00);
    rd(rtm_pkg::OFS_TIMER_COUNT_HIGH, d);
    chk(d, 8'h77);
    rd(rtm_pkg::OFS_TIMER_COUNT_LOW, d);
    in_range(d, 8'hE0, 8'hF0);
    wr(rtm_pkg::OFS_TIMER_COUNT_HIGH, 8'hFE);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h0C);
    wait_flag(8'h80);
    chk({7'h00, d[7]}, 8'h01);
    rd(rtm_pkg::OFS_TIMER_COUNT_HIGH, d);
    in_range(d, 8'h80, 8'h8F);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h08);
    HIGH_BYTE_FAST_CLOCK_SELECT = 1'b0;
    $display("test split done");
  endtask

  // alternate clocks: system clock /12, then external source /8 falls
  task automatic t_altclk();
    LOW_BYTE_FAST_CLOCK_SELECT = 1'b0;
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h00);
    set_count(8'h00, 8'h00);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h04);
    repeat (120) @(negedge CLK);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h00);
    rd(rtm_pkg::OFS_TIMER_COUNT_LOW, d);
    in_range(d, 8'h09, 8'h0B);
    set_count(8'h00, 8'h00);
    ext_run = 1'b1;
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h05);
    repeat (400) @(negedge CLK);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h01);
    rd(rtm_pkg::OFS_TIMER_COUNT_LOW, d);
    in_range(d, 8'h09, 8'h0B);
    // split: high byte with fast select off follows the external falls too
    set_count(8'h00, 8'h00);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h0D);
    repeat (400) @(negedge CLK);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h09);
    rd(rtm_pkg::OFS_TIMER_COUNT_HIGH, d);
    in_range(d, 8'h09, 8'h0B);
    $display("test clocks done");
  endtask

  // capture: two successive captures one external period apart
  task automatic t_capture();
    LOW_BYTE_FAST_CLOCK_SELECT = 1'b1;
    set_count(8'h00, 8'h00);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h14);
    for (int k = 0; k < 3; k++) begin
      wait_flag(8'h80);
      rd(rtm_pkg::OFS_TIMER_RELOAD_LOW, lo);
      rd(rtm_pkg::OFS_TIMER_RELOAD_HIGH, hi);
      if (k == 2) begin
        cap = {hi, lo} - cap;
        chk(cap[15:8], 8'h00);
        chk(cap[7:0], 8'h28);
      end
      cap = {hi, lo};
      wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h14);
    end
    chk({7'h00, d[7]}, 8'h01);
    wr(rtm_pkg::OFS_TIMER_CONTROL, 8'h00);
    ext_run = 1'b0;
    $display("test capture done");
  endtask

  // ---------------------------------------------------------------
  // verdict and main sequence
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    t_reset();
    t_regs();
    t_wrap16();
    t_split();
    t_altclk();
    t_capture();
    print_verdict();
  end
endmodule
